// *** verilog/cff_defs.vh ***
// register offsets, field positions and reset values of the charger fault and event flag bank
`ifndef CFF_DEFS_VH
`define CFF_DEFS_VH
`define CFF_ADDR_W 8
`define CFF_FAULT_STATUS_SECOND_IDX 8'h21
`define CFF_EVENT_FLAGS_FIRST_IDX 8'h22
`define CFF_EVENT_FLAGS_SECOND_IDX 8'h23
`define CFF_REG_RESET 8'h00
`define CFF_FS_SYS_SHORT 7
`define CFF_FS_SYS_OVP 6
`define CFF_FS_REV_OVP 5
`define CFF_FS_REV_UVP 4
`define CFF_FS_TSHUT 2
`define CFF_EF1_ICURR 7
`define CFF_EF1_VREG 6
`define CFF_EF1_WDOG 5
`define CFF_EF1_WEAK 4
`define CFF_EF1_PGOOD 3
`define CFF_EF1_IN2 2
`define CFF_EF1_IN1 1
`define CFF_EF1_BUS 0
`define CFF_EF2_CHG 7
`define CFF_EF2_OPT 6
`define CFF_EF2_BUSTYPE 4
`define CFF_EF2_DIE_THERMAL_REGULATION 2
`define CFF_EF2_BATT 1
`define CFF_EF2_PORTDET 0
`define CFF_RESP_OKAY 2'b00
`define CFF_RESP_SLVERR 2'b10
`endif

// *** verilog/cff_charger_flags.v ***
// charger fault status and event flag bank behind an axi4-lite slave
// Behaviour
// - fault status bit 7 follows system rail short protection live.
// - fault status bit 6 follows system rail over-voltage protection live.
// - fault status bit 5 follows reverse output over-voltage live.
// - fault status bit 4 follows reverse output under-voltage live.
// - fault status bit 2 follows thermal shutdown; bits 3,1,0 read zero.
// - first flags bit 7 sets on rising input or reverse current regulation.
// - first flags bit 6 sets on rising input or reverse voltage regulation.
// - first flags bit 5 sets on rising host watchdog expiry.
// - first flags bit 4 sets on rising weak source status.
// - first flags bit 3 sets on any power good change.
// - first flags bit 2 sets on second input presence change.
// - first flags bit 1 sets on first input presence change.
// - first flags bit 0 sets on main input bus presence change.
// - second flags bit 7 sets on charge state change.
// - second flags bit 6 sets on optimizer change; bits 5,3 read zero.
// - second flags bit 4 sets on input bus type change.
// - second flags bit 2 sets on rising die thermal regulation.
// - second flags bit 1 sets on battery presence change.
// - second flags bit 0 sets on port detection status change.
// - three read-only registers at 21h..23h, all zero after reset.
`include "cff_defs.vh"
`default_nettype none
module cff_charger_flags #(
	parameter CHG_STATE_W = 3,
	parameter BUS_TYPE_W = 4
) (
	input wire ref_clk,
	input wire resetn,
	input wire system_rail_short_status,
	input wire system_rail_overvoltage_status,
	input wire reverse_output_overvoltage_status,
	input wire reverse_output_undervoltage_status,
	input wire thermal_shutdown_status,
	input wire input_current_regulation,
	input wire reverse_output_current_regulation,
	input wire input_voltage_regulation,
	input wire reverse_output_voltage_regulation,
	input wire host_watchdog_expiry,
	input wire weak_source_status,
	input wire power_good_status,
	input wire second_input_present,
	input wire first_input_present,
	input wire main_input_bus_present,
	input wire [CHG_STATE_W-1:0] charge_state,
	input wire input_current_optimizer_status,
	input wire [BUS_TYPE_W-1:0] input_bus_type,
	input wire die_thermal_regulation,
	input wire battery_present,
	input wire port_detection_status,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	localparam SW = 19 + CHG_STATE_W + BUS_TYPE_W;

	// raw condition vector, all from outside the clock domain
	// every pin is synchronised alone; pairs are merged afterwards
	wire [SW-1:0] rawIn;
	assign rawIn = {
		system_rail_short_status,
		system_rail_overvoltage_status,
		reverse_output_overvoltage_status,
		reverse_output_undervoltage_status,
		thermal_shutdown_status,
		input_current_regulation,
		reverse_output_current_regulation,
		input_voltage_regulation,
		reverse_output_voltage_regulation,
		host_watchdog_expiry,
		weak_source_status,
		power_good_status,
		second_input_present,
		first_input_present,
		main_input_bus_present,
		charge_state,
		input_current_optimizer_status,
		input_bus_type,
		die_thermal_regulation,
		battery_present,
		port_detection_status
	};

	reg [SW-1:0] sync1_q;
	reg [SW-1:0] sync2_q;
	reg [SW-1:0] prev_q;
	reg [7:0] faultStat_q;
	reg [7:0] flagsA_q;
	reg [7:0] flagsB_q;
	reg [7:0] flagsA_d;
	reg [7:0] flagsB_d;
	reg [7:0] evA;
	reg [7:0] evB;
	reg [7:0] clrA;
	reg [7:0] clrB;
	reg awSeen_q;
	reg wSeen_q;

	// synchronised fields
	wire [SW-1:0] rise;
	wire [SW-1:0] chg;
	genvar gi;
	generate
		for (gi = 0; gi < SW; gi = gi + 1) begin : g_edge
			assign rise[gi] = sync2_q[gi] & ~prev_q[gi];
			assign chg[gi] = sync2_q[gi] ^ prev_q[gi];
		end
	endgenerate
	localparam P_PORT = 0;
	localparam P_BATT = 1;
	localparam P_DIE_THERMAL_REGULATION = 2;
	localparam P_BTYPE = 3;
	localparam P_OPT = 3 + BUS_TYPE_W;
	localparam P_CHG = P_OPT + 1;
	localparam P_BUS = P_CHG + CHG_STATE_W;
	localparam P_IN1 = P_BUS + 1;
	localparam P_IN2 = P_BUS + 2;
	localparam P_PG = P_BUS + 3;
	localparam P_WEAK = P_BUS + 4;
	localparam P_WDOG = P_BUS + 5;
	localparam P_VREV = P_BUS + 6;
	localparam P_VREG = P_BUS + 7;
	localparam P_IREV = P_BUS + 8;
	localparam P_IREG = P_BUS + 9;
	localparam P_TSHUT = P_BUS + 10;
	localparam P_RUVP = P_BUS + 11;
	localparam P_ROVP = P_BUS + 12;
	localparam P_SOVP = P_BUS + 13;
	localparam P_SSHORT = P_BUS + 14;

	// address decode used for read data and error answer
	function [1:0] decodeSel;
		input [31:0] addr;
		begin
			if (addr[1:0] != 2'b00 || addr[31:10] != 22'h0) begin
				decodeSel = 2'd0;
			end else if (addr[9:2] == `CFF_FAULT_STATUS_SECOND_IDX) begin
				decodeSel = 2'd1;
			end else if (addr[9:2] == `CFF_EVENT_FLAGS_FIRST_IDX) begin
				decodeSel = 2'd2;
			end else if (addr[9:2] == `CFF_EVENT_FLAGS_SECOND_IDX) begin
				decodeSel = 2'd3;
			end else begin
				decodeSel = 2'd0;
			end
		end
	endfunction

	// rising edge of two merged regulation lines
	function pairRise;
		input nowA;
		input nowB;
		input oldA;
		input oldB;
		begin
			pairRise = (nowA | nowB) & ~(oldA | oldB);
		end
	endfunction

	// next flag value: clear on read, a new event wins
	function [7:0] flagNext;
		input [7:0] cur;
		input [7:0] ev;
		input [7:0] clr;
		begin
			flagNext = (cur & ~clr) | ev;
		end
	endfunction

	// read data word for a decoded register
	function [31:0] readWord;
		input [1:0] sel;
		input [7:0] fs;
		input [7:0] fa;
		input [7:0] fb;
		begin
			case (sel)
			2'd1: begin
				readWord = {24'h000000, fs};
			end
			2'd2: begin
				readWord = {24'h000000, fa};
			end
			2'd3: begin
				readWord = {24'h000000, fb};
			end
			default: begin
				readWord = 32'h00000000;
			end
			endcase
		end
	endfunction

	wire readTake;
	wire [1:0] rdSel;
	assign readTake = s_axi_arvalid & s_axi_arready;
	assign rdSel = decodeSel(s_axi_araddr);

	always @* begin
		evA = 8'h00;
		evB = 8'h00;
		evA[`CFF_EF1_ICURR] = pairRise(sync2_q[P_IREG], sync2_q[P_IREV], prev_q[P_IREG], prev_q[P_IREV]);
		evA[`CFF_EF1_VREG] = pairRise(sync2_q[P_VREG], sync2_q[P_VREV], prev_q[P_VREG], prev_q[P_VREV]);
		evA[`CFF_EF1_WDOG] = rise[P_WDOG];
		evA[`CFF_EF1_WEAK] = rise[P_WEAK];
		evA[`CFF_EF1_PGOOD] = chg[P_PG];
		evA[`CFF_EF1_IN2] = chg[P_IN2];
		evA[`CFF_EF1_IN1] = chg[P_IN1];
		evA[`CFF_EF1_BUS] = chg[P_BUS];
		evB[`CFF_EF2_CHG] = |chg[P_CHG +: CHG_STATE_W];
		evB[`CFF_EF2_OPT] = chg[P_OPT];
		evB[`CFF_EF2_BUSTYPE] = |chg[P_BTYPE +: BUS_TYPE_W];
		evB[`CFF_EF2_DIE_THERMAL_REGULATION] = rise[P_DIE_THERMAL_REGULATION];
		evB[`CFF_EF2_BATT] = chg[P_BATT];
		evB[`CFF_EF2_PORTDET] = chg[P_PORT];
		clrA = (readTake && rdSel == 2'd2) ? 8'hff : 8'h00;
		clrB = (readTake && rdSel == 2'd3) ? 8'hff : 8'h00;
		flagsA_d = flagNext(flagsA_q, evA, clrA);
		flagsB_d = flagNext(flagsB_q, evB, clrB);
	end

	// two-flop synchroniser and edge history
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= {SW{1'b0}};
			sync2_q <= {SW{1'b0}};
			prev_q <= {SW{1'b0}};
		end else begin
			sync1_q <= rawIn;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// register bank
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			faultStat_q <= `CFF_REG_RESET;
			flagsA_q <= `CFF_REG_RESET;
			flagsB_q <= `CFF_REG_RESET;
		end else begin
			faultStat_q <= {sync2_q[P_SSHORT], sync2_q[P_SOVP], sync2_q[P_ROVP], sync2_q[P_RUVP],
				1'b0, sync2_q[P_TSHUT], 2'b00};
			flagsA_q <= flagsA_d;
			flagsB_q <= flagsB_d;
		end
	end

	// write channel: address and data taken in either order, answered with slverr
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CFF_RESP_OKAY;
			awSeen_q <= 1'b0;
			wSeen_q <= 1'b0;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (s_axi_bvalid) begin
				if (s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end else if (awSeen_q && wSeen_q) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `CFF_RESP_SLVERR;
				awSeen_q <= 1'b0;
				wSeen_q <= 1'b0;
			end else begin
				if (s_axi_awvalid && !s_axi_awready && !awSeen_q) begin
					s_axi_awready <= 1'b1;
				end
				if (s_axi_awvalid && s_axi_awready) begin
					awSeen_q <= 1'b1;
				end
				if (s_axi_wvalid && !s_axi_wready && !wSeen_q) begin
					s_axi_wready <= 1'b1;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					wSeen_q <= 1'b1;
				end
			end
		end
	end

	// read channel
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `CFF_RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid) begin
				if (s_axi_rready) begin
					s_axi_rvalid <= 1'b0;
				end
			end else if (s_axi_arvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
			end else if (readTake) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= (rdSel == 2'd0) ? `CFF_RESP_SLVERR : `CFF_RESP_OKAY;
				s_axi_rdata <= readWord(rdSel, faultStat_q, flagsA_q, flagsB_q);
			end
		end
	end
endmodule // cff_charger_flags
`default_nettype wire

// *** tb/cff_charger_flags_props.sv ***
// port assertions for the charger flag bank
`default_nettype none
module cff_charger_flags_props (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic system_rail_short_status,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_bvalid,
	input wire logic [1:0] s_axi_bresp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] ra_q;
	logic hit;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	assign hit = ra_q inside {32'h84, 32'h88, 32'h8c};
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			ra_q <= 32'h0;
		else if (s_axi_arvalid && s_axi_arready)
			ra_q <= s_axi_araddr;
	end
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read answer");
	a_answer_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
		else $error("read answer without request");
	a_no_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_write_refused: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h2)
		else $error("write not refused");
	a_map_resp: assert property (s_axi_rvalid |-> s_axi_rresp == (hit ? 2'h0 : 2'h2) && (hit || s_axi_rdata == 32'h0))
		else $error("wrong read response");
	a_resvd_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & (ra_q == 32'h84 ? 32'hb :
		(ra_q == 32'h8c ? 32'h28 : 32'h0))) == 32'h0) else $error("reserved bit set");
	a_short_live: assert property ($rose(s_axi_rvalid) && ra_q == 32'h84 &&
		$past(system_rail_short_status, 4) && $past(system_rail_short_status, 7) |-> s_axi_rdata[7])
		else $error("short status not shown");
	c_flag: cover property (s_axi_rvalid && ra_q == 32'h88 && s_axi_rdata != 32'h0);
	c_unmapped: cover property (s_axi_rvalid && !hit);
	c_write: cover property (s_axi_bvalid);
endmodule // cff_charger_flags_props
bind cff_charger_flags cff_charger_flags_props u_props (.*);
`default_nettype wire

// *** tb/cff_charger_flags_tb_top.sv ***
// self-checking bench of the charger flag bank
`default_nettype none
module cff_charger_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rstN = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic awr, wr, bv, arr, rv;
	logic [1:0] br, rr;
	logic [31:0] addr = 32'h0, wd = 32'h0, rdat;
	logic [3:0] ws = 4'h0;
	logic [4:0] flt = 5'h0;
	logic [20:0] ev = 21'h0;
	int n_fail = 0, samples_checked = 0;
	byte bitOf [21] = '{7, 7, 6, 6, 5, 4, 3, 2, 1, 0, 6, 2, 1, 0, 7, 7, 7, 4, 4, 4, 4};
	always #25 clk = ~clk;
	cff_charger_flags DUT (.ref_clk(clk), .resetn(rstN), .system_rail_short_status(flt[4]),
		.system_rail_overvoltage_status(flt[3]), .reverse_output_overvoltage_status(flt[2]),
		.reverse_output_undervoltage_status(flt[1]), .thermal_shutdown_status(flt[0]),
		.input_current_regulation(ev[0]), .reverse_output_current_regulation(ev[1]),
		.input_voltage_regulation(ev[2]), .reverse_output_voltage_regulation(ev[3]),
		.host_watchdog_expiry(ev[4]), .weak_source_status(ev[5]), .power_good_status(ev[6]),
		.second_input_present(ev[7]), .first_input_present(ev[8]), .main_input_bus_present(ev[9]),
		.input_current_optimizer_status(ev[10]), .die_thermal_regulation(ev[11]), .battery_present(ev[12]),
		.port_detection_status(ev[13]), .charge_state(ev[16:14]), .input_bus_type(ev[20:17]),
		.s_axi_awaddr(addr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(addr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
	task automatic ck(string nm, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rd(logic [31:0] a, logic [7:0] e, logic [1:0] r = 2'h0);
		addr <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		rry <= 1'b0;
		ck("rdata", {24'h0, e}, rdat);
		ck("rresp", {30'h0, r}, {30'h0, rr});
		@(posedge clk);
	endtask
	task automatic wrt(logic [31:0] a);
		logic awOpen = 1'b1;
		logic wOpen = 1'b1;
		addr <= a;
		wd <= 32'hff;
		ws <= 4'hf;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			if (awOpen && awr === 1'b1) begin
				awv <= 1'b0;
				awOpen = 1'b0;
			end
			if (wOpen && wr === 1'b1) begin
				wv <= 1'b0;
				wOpen = 1'b0;
			end
		end while (awOpen || wOpen);
		do @(posedge clk); while (bv !== 1'b1);
		bry <= 1'b0;
		ck("bresp", 32'h2, {30'h0, br});
		@(posedge clk);
	endtask
	task automatic t_access;
		rd(32'h84, 8'h0);
		rd(32'h88, 8'h0);
		rd(32'h8c, 8'h0);
		rd(32'h90, 8'h0, 2'h2);
		rd(32'h85, 8'h0, 2'h2);
		rd(32'h484, 8'h0, 2'h2);
		wrt(32'h84);
		rd(32'h84, 8'h0);
	endtask
	task automatic t_fault;
		logic [4:0] f;
		for (int i = 0; i <= 6; i++) begin
			f = i < 5 ? 5'h1 << i : (i == 5 ? 5'h1f : 5'h0);
			flt <= f;
			repeat (5) @(posedge clk);
			rd(32'h84, {f[4:1], 1'b0, f[0], 2'h0});
		end
	endtask
	task automatic t_flags;
		logic [7:0] m;
		for (int i = 0; i < 21; i++) begin
			m = 8'h1 << bitOf[i];
			ev[i] <= 1'b1;
			repeat (8) @(posedge clk);
			rd(32'h88, i < 10 ? m : 8'h0);
			rd(32'h8c, i < 10 ? 8'h0 : m);
			ev[i] <= 1'b0;
			repeat (5) @(posedge clk);
			rd(i < 10 ? 32'h88 : 32'h8c, (i < 6 || i == 11) ? 8'h0 : m);
		end
	endtask
	task give_verdict;
		if (n_fail == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rstN <= 1'b1;
		@(posedge clk);
		t_access();
		t_fault();
		t_flags();
		give_verdict();
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		give_verdict();
	end
endmodule // cff_charger_flags_tb_top
`default_nettype wire
